// *** src/ssw_defs.svh ***
// Timing constants and synchronised input positions for the supply supervisor
`ifndef SSW_DEFS_SVH
`define SSW_DEFS_SVH

`define SSW_CLK_MHZ        250
`define SSW_T_RESET_MS     200
`define SSW_T_WDOG_MS      1600
`define SSW_T_CE_US        10
`define SSW_RESET_CYC      (`SSW_T_RESET_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_WDOG_CYC       (`SSW_T_WDOG_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_CE_CYC         (`SSW_T_CE_US * `SSW_CLK_MHZ)

`define SSW_SYNC_W         12
`define SSW_IN_MR          0
`define SSW_IN_KICK        1
`define SSW_IN_VTRIP       2
`define SSW_IN_VSW         3
`define SSW_IN_VBAT        4
`define SSW_IN_VFLOOR      5
`define SSW_IN_BTRIP       6
`define SSW_IN_BGOOD       7
`define SSW_IN_PFI         8
`define SSW_IN_VLL         9
`define SSW_IN_CE          10
`define SSW_IN_PFPIN       11

// Idle pin levels, so no false edge or output glitch follows reset
`define SSW_SYNC_RST_VAL   12'hFBD

`endif

// *** src/ssw_pkg.sv ***
// Types shared by the supply supervisor
`default_nettype none
package ssw_pkg;

  typedef enum logic [0:0] {
    SSW_SRC_MAIN,
    SSW_SRC_BACKUP
  } ssw_src_e;

  typedef enum logic [1:0] {
    SSW_SEAL_IDLE,
    SSW_SEAL_PENDING,
    SSW_SEAL_ARMED,
    SSW_SEAL_SEALED
  } ssw_seal_e;

endpackage : ssw_pkg
`default_nettype wire

// *** src/ssw_sync.sv ***
// Two-flop synchroniser for the asynchronous comparator and pin inputs
`timescale 1ns/1ps
`default_nettype none
`include "ssw_defs.svh"

module ssw_sync (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic [`SSW_SYNC_W-1:0]   async_in,
  output var  logic [`SSW_SYNC_W-1:0]   sync_out
);

  logic [`SSW_SYNC_W-1:0] meta_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q   <= `SSW_SYNC_RST_VAL;
      sync_out <= `SSW_SYNC_RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : ssw_sync
`default_nettype wire

// *** src/ssw_top.sv ***
// Supply supervisor: reset generation, watchdog, chip-enable gating, backup switchover
// Contract
// - Reset held while manual reset low and 200 ms after release, except in first half of timeout with power fail pin forced low.
// - Reset low below trip threshold; 200 ms after any cause ends.
// - Active-high reset is always the inverse of active-low reset.
// - Kick stuck past timeout drives fault low; next kick edge restores it.
// - Fault forced high between switch and trip threshold, low below switch.
// - Gated chip enable low only when input low and reset inactive or in the reset-start hold.
// - Input low at reset start keeps output low 10 us or until input high.
// - Switch driver high on backup, low on main supply.
// - Main above trip or backup; backup below switch and backup voltage.
// - Below switch but above backup voltage, stay on main.
// - Below supply floor, select backup unless the seal is on.
// - Backup above supply, supply above switch: stay on main.
// - Return to main at trip crossing if backup above trip, else above backup.
// - Battery good follows comparator outside reset, holds its value during reset, held low below switch threshold.
// - Power fail low when sense low or supply below switch.
// - Power fail pin also sampled as input to arm the seal.
// - Early warning low when supply falls to low-line threshold.
// - Watchdog 1.6 s; cleared during reset; restarts on release or kick.
// - Fault released 10 us after reset asserts.
// - Seal armed by pin low through reset release; cleared when supply drops below trip and then returns above it.
`timescale 1ns/1ps
`default_nettype none
`include "ssw_defs.svh"

module ssw_top #(
  parameter logic [31:0] RESET_CYC = `SSW_RESET_CYC,
  parameter logic [31:0] WDOG_CYC  = `SSW_WDOG_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic manual_reset_n,
  input  wire logic watchdog_kick,
  input  wire logic vcc_above_trip,
  input  wire logic vcc_above_switch,
  input  wire logic vcc_above_backup,
  input  wire logic vcc_above_floor,
  input  wire logic backup_above_trip,
  input  wire logic backup_above_good,
  input  wire logic power_fail_sense,
  input  wire logic vcc_above_low_line,
  input  wire logic chip_enable_in_n,
  input  wire logic power_fail_in,
  output var  logic reset_n,
  output var  logic reset_hi,
  output var  logic watchdog_fault_n,
  output var  logic chip_enable_out_n,
  output var  logic ram_on_backup,
  output var  logic backup_selected,
  output var  logic battery_good,
  output var  logic power_fail_n,
  output var  logic power_fail_oe,
  output var  logic early_power_warning_n,
  output var  logic seal_armed
);

  logic [`SSW_SYNC_W-1:0] s_in;
  logic                   s_mr_n;
  logic                   s_kick;
  logic                   s_vtrip;
  logic                   s_vsw;
  logic                   s_vbat;
  logic                   s_vfloor;
  logic                   s_btrip;
  logic                   s_bgood;
  logic                   s_pfi;
  logic                   s_vll;
  logic                   s_ce_n;
  logic                   s_pfpin;

  logic                   rst_act_q;
  logic                   rst_act_prev_q;
  logic [31:0]            rst_cnt_q;
  logic [11:0]            rst_age_q;
  logic                   mr_ignore;
  logic                   cause;
  logic                   age_done;

  logic                   kick_prev_q;
  logic                   kick_edge;
  logic [31:0]            wd_cnt_q;
  logic                   fault_q;

  logic                   ce_hold_q;
  logic                   ce_keep;

  ssw_pkg::ssw_src_e      src_q;
  ssw_pkg::ssw_src_e      src_d;
  ssw_pkg::ssw_seal_e     seal_q;
  ssw_pkg::ssw_seal_e     seal_d;
  logic                   seal_on;
  logic                   to_backup;
  logic                   to_main;

  logic                   pf_drv_d1_q;
  logic                   pf_drv_d2_q;
  logic                   pf_forced;

  ssw_sync u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({power_fail_in, chip_enable_in_n, vcc_above_low_line, power_fail_sense,
                backup_above_good, backup_above_trip, vcc_above_floor, vcc_above_backup,
                vcc_above_switch, vcc_above_trip, watchdog_kick, manual_reset_n}),
    .sync_out (s_in)
  );

  assign s_mr_n   = s_in[`SSW_IN_MR];
  assign s_kick   = s_in[`SSW_IN_KICK];
  assign s_vtrip  = s_in[`SSW_IN_VTRIP];
  assign s_vsw    = s_in[`SSW_IN_VSW];
  assign s_vbat   = s_in[`SSW_IN_VBAT];
  assign s_vfloor = s_in[`SSW_IN_VFLOOR];
  assign s_btrip  = s_in[`SSW_IN_BTRIP];
  assign s_bgood  = s_in[`SSW_IN_BGOOD];
  assign s_pfi    = s_in[`SSW_IN_PFI];
  assign s_vll    = s_in[`SSW_IN_VLL];
  assign s_ce_n   = s_in[`SSW_IN_CE];
  assign s_pfpin  = s_in[`SSW_IN_PFPIN];

  // pin low while we are not pulling it means someone else is
  // Drive history covers the synchroniser lag after we let go
  assign pf_forced = !s_pfpin && !power_fail_oe && !pf_drv_d1_q && !pf_drv_d2_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pf_drv_d1_q <= 1'b0;
      pf_drv_d2_q <= 1'b0;
    end else begin
      pf_drv_d1_q <= power_fail_oe;
      pf_drv_d2_q <= pf_drv_d1_q;
    end
  end

  // Manual reset ignored in first half of timeout while seal is being armed
  assign mr_ignore = pf_forced && rst_act_q && (rst_cnt_q < (RESET_CYC >> 1));
  assign cause     = !s_vtrip || (!s_mr_n && !mr_ignore);
  assign age_done  = (rst_age_q == 12'(`SSW_CE_CYC));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rst_act_q <= 1'b1;
      rst_cnt_q <= 32'h0000_0000;
    end else if (cause) begin
      rst_act_q <= 1'b1;
      rst_cnt_q <= 32'h0000_0000;
    end else if (rst_act_q) begin
      if (rst_cnt_q == RESET_CYC - 32'h1) begin
        rst_act_q <= 1'b0;
      end else begin
        rst_cnt_q <= rst_cnt_q + 32'h1;
      end
    end
  end

  // Time since reset asserted, saturating
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rst_age_q      <= 12'h000;
      // Matches rst_act_q so leaving reset is not seen as a fresh reset start
      rst_act_prev_q <= 1'b1;
    end else begin
      rst_act_prev_q <= rst_act_q;
      if (!rst_act_q) begin
        rst_age_q <= 12'h000;
      end else if (!age_done) begin
        rst_age_q <= rst_age_q + 12'h001;
      end
    end
  end

  // both levels from one state bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reset_n  <= 1'b0;
      reset_hi <= 1'b1;
    end else begin
      reset_n  <= !rst_act_q;
      reset_hi <= rst_act_q;
    end
  end

  assign kick_edge = s_kick ^ kick_prev_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      kick_prev_q <= 1'b0;
      wd_cnt_q    <= 32'h0000_0000;
    end else begin
      kick_prev_q <= s_kick;
      if (rst_act_q || kick_edge) begin
        wd_cnt_q <= 32'h0000_0000;
      end else if (wd_cnt_q != WDOG_CYC) begin
        wd_cnt_q <= wd_cnt_q + 32'h1;
      end
    end
  end

  // fault on timeout, cleared by kick
  // fault cleared 10 us into reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else if (kick_edge || (rst_act_q && age_done)) begin
      fault_q <= 1'b0;
    end else if (!rst_act_q && wd_cnt_q == WDOG_CYC - 32'h1) begin
      fault_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      watchdog_fault_n <= 1'b0;
    end else if (!s_vsw) begin
      watchdog_fault_n <= 1'b0;
    end else if (!s_vtrip) begin
      watchdog_fault_n <= 1'b1;
    end else begin
      watchdog_fault_n <= !fault_q;
    end
  end

  // keep a running access alive briefly into reset
  assign ce_keep = ce_hold_q || (rst_act_q && !rst_act_prev_q && !s_ce_n);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ce_hold_q <= 1'b0;
    end else if (rst_act_q && !rst_act_prev_q && !s_ce_n) begin
      ce_hold_q <= 1'b1;
    end else if (s_ce_n || !rst_act_q || age_done) begin
      ce_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chip_enable_out_n <= 1'b1;
    end else begin
      chip_enable_out_n <= !(!s_ce_n && (!rst_act_q || ce_keep));
    end
  end

  // backup below switch and backup voltage, or below floor
  assign to_backup = !s_vfloor || (!s_vsw && !s_vbat);
  // return point depends on backup against trip
  assign to_main   = s_vfloor && (s_vtrip || (!s_btrip && s_vbat));
  assign seal_on   = (seal_q == ssw_pkg::SSW_SEAL_ARMED) || (seal_q == ssw_pkg::SSW_SEAL_SEALED);

  always_comb begin
    src_d = src_q;
    case (src_q)
      ssw_pkg::SSW_SRC_MAIN: begin
        if (to_backup && !seal_on) begin
          src_d = ssw_pkg::SSW_SRC_BACKUP;
        end
      end
      ssw_pkg::SSW_SRC_BACKUP: begin
        if (seal_on || (to_main && !to_backup)) begin
          src_d = ssw_pkg::SSW_SRC_MAIN;
        end
      end
      default: src_d = ssw_pkg::SSW_SRC_MAIN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      src_q <= ssw_pkg::SSW_SRC_MAIN;
    end else begin
      src_q <= src_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ram_on_backup   <= 1'b0;
      backup_selected <= 1'b0;
    end else begin
      ram_on_backup   <= (src_q == ssw_pkg::SSW_SRC_BACKUP);
      backup_selected <= (src_q == ssw_pkg::SSW_SRC_BACKUP);
    end
  end

  always_comb begin
    seal_d = seal_q;
    case (seal_q)
      ssw_pkg::SSW_SEAL_IDLE: begin
        if (rst_act_q && s_vtrip && pf_forced) begin
          seal_d = ssw_pkg::SSW_SEAL_PENDING;
        end
      end
      ssw_pkg::SSW_SEAL_PENDING: begin
        if (!s_vtrip) begin
          seal_d = ssw_pkg::SSW_SEAL_IDLE;
        end else if (!rst_act_q) begin
          seal_d = pf_forced ? ssw_pkg::SSW_SEAL_ARMED : ssw_pkg::SSW_SEAL_IDLE;
        end
      end
      ssw_pkg::SSW_SEAL_ARMED: begin
        if (!s_vtrip) begin
          seal_d = ssw_pkg::SSW_SEAL_SEALED;
        end
      end
      ssw_pkg::SSW_SEAL_SEALED: begin
        if (s_vtrip) begin
          seal_d = ssw_pkg::SSW_SEAL_IDLE;
        end
      end
      default: seal_d = ssw_pkg::SSW_SEAL_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seal_q     <= ssw_pkg::SSW_SEAL_IDLE;
      seal_armed <= 1'b0;
    end else begin
      seal_q     <= seal_d;
      seal_armed <= seal_on;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      battery_good <= 1'b0;
    end else if (!s_vsw) begin
      battery_good <= 1'b0;
    end else if (!rst_act_q) begin
      battery_good <= s_bgood;
    end
  end

  // power fail, pulled low as open drain so the pin can be overdriven
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      power_fail_n  <= 1'b1;
      power_fail_oe <= 1'b0;
    end else begin
      power_fail_n  <= s_pfi && s_vsw;
      power_fail_oe <= !(s_pfi && s_vsw);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      early_power_warning_n <= 1'b1;
    end else begin
      early_power_warning_n <= s_vll;
    end
  end

  reset_inverse_a: assert property (@(posedge ref_clk) disable iff (rst)
    reset_hi == !reset_n) else $error("reset outputs not inverse");

  reset_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
    cause |=> rst_act_q ##1 reset_hi) else $error("cause did not assert reset");

  reset_release_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst_act_q) |-> $past(rst_cnt_q) == RESET_CYC - 32'h1 && !$past(cause))
    else $error("reset released before full timeout");

  wdo_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    !s_vsw |=> !watchdog_fault_n) else $error("fault not forced low below switch");

  wdo_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_vsw && !s_vtrip |=> watchdog_fault_n) else $error("fault not forced high");

  wd_cleared_a: assert property (@(posedge ref_clk) disable iff (rst)
    rst_act_q |=> wd_cnt_q == 32'h0000_0000) else $error("watchdog counted in reset");

  fault_release_a: assert property (@(posedge ref_clk) disable iff (rst)
    rst_act_q && age_done && !kick_edge |=> !fault_q ##1 (!s_vtrip || !s_vsw || watchdog_fault_n))
    else $error("fault not released in reset");

  ce_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    !chip_enable_out_n |-> $past(!s_ce_n)) else $error("chip enable low without input");

  ce_window_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce_hold_q |-> rst_age_q <= 12'(`SSW_CE_CYC)) else $error("chip enable held past window");

  drv_match_a: assert property (@(posedge ref_clk) disable iff (rst)
    backup_selected == ram_on_backup) else $error("switch driver disagrees with selection");

  floor_backup_a: assert property (@(posedge ref_clk) disable iff (rst)
    !s_vfloor && !seal_on && !rst_act_prev_q |-> ##2 ram_on_backup) else $error("floor did not select backup");

  pfo_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!s_pfi || !s_vsw) |=> !power_fail_n && power_fail_oe) else $error("power fail not low");

  bok_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    !s_vsw |=> !battery_good) else $error("battery good high below switch");

endmodule : ssw_top
`default_nettype wire

// *** tb/ssw_cpu_model.sv ***
// Processor side model: watchdog kicks and the open-drain power-fail pin
`timescale 1ns/1ps
`default_nettype none

module ssw_cpu_model #(
  parameter int KICK_GAP = 40
) (
  input  wire logic ref_clk,
  input  wire logic kick_en,
  input  wire logic pf_force,
  input  wire logic power_fail_oe,
  output var  logic watchdog_kick,
  output var  logic power_fail_in
);
  int gap_cnt = 0;

  initial watchdog_kick = 1'b0;

  always @(posedge ref_clk) begin
    if (kick_en) begin
      gap_cnt <= (gap_cnt == KICK_GAP - 1) ? 0 : gap_cnt + 1;
      if (gap_cnt == KICK_GAP - 1) begin
        watchdog_kick <= ~watchdog_kick;
      end
    end
  end

  // pin low when either side pulls, pull-up otherwise
  assign power_fail_in = (power_fail_oe || pf_force) ? 1'b0 : 1'b1;
endmodule : ssw_cpu_model
`default_nettype wire

// *** tb/test_ssw_top.sv ***
// Self-checking testbench for the supply supervisor
`timescale 1ns/1ps
`default_nettype none

module test_ssw_top;
  // Short counts keep the run small
  localparam logic [31:0] RC = 32'h40;
  localparam logic [31:0] WC = 32'hC8;

  logic ref_clk            = 1'b0;
  logic rst                = 1'b1;
  logic manual_reset_n     = 1'b1;
  logic vcc_above_trip     = 1'b1;
  logic vcc_above_switch   = 1'b1;
  logic vcc_above_backup   = 1'b1;
  logic vcc_above_floor    = 1'b1;
  logic backup_above_trip  = 1'b0;
  logic backup_above_good  = 1'b1;
  logic power_fail_sense   = 1'b1;
  logic vcc_above_low_line = 1'b1;
  logic chip_enable_in_n   = 1'b1;
  logic kick_en            = 1'b1;
  logic pf_force           = 1'b0;
  logic mr_loop            = 1'b0;
  logic watchdog_kick;
  logic power_fail_in;
  logic reset_n;
  logic reset_hi;
  logic watchdog_fault_n;
  logic chip_enable_out_n;
  logic ram_on_backup;
  logic backup_selected;
  logic battery_good;
  logic power_fail_n;
  logic power_fail_oe;
  logic early_power_warning_n;
  logic seal_armed;
  int   miscompares  = 0;
  int   total_checks = 0;
  // {trip, switch, above backup, floor, backup above trip, expected backup}
  logic [5:0] sup_tab [0:9] = '{6'h3C, 6'h0C, 6'h05, 6'h0F, 6'h3E, 6'h16, 6'h07, 6'h0C, 6'h19, 6'h3C};

  always #2 ref_clk = ~ref_clk;

  // Diode-OR of fault output onto manual reset
  always @(posedge ref_clk) begin
    if (mr_loop) begin
      manual_reset_n <= watchdog_fault_n;
    end
  end

  ssw_top #(.RESET_CYC(RC), .WDOG_CYC(WC)) uut (
    .ref_clk               (ref_clk),
    .rst                   (rst),
    .manual_reset_n        (manual_reset_n),
    .watchdog_kick         (watchdog_kick),
    .vcc_above_trip        (vcc_above_trip),
    .vcc_above_switch      (vcc_above_switch),
    .vcc_above_backup      (vcc_above_backup),
    .vcc_above_floor       (vcc_above_floor),
    .backup_above_trip     (backup_above_trip),
    .backup_above_good     (backup_above_good),
    .power_fail_sense      (power_fail_sense),
    .vcc_above_low_line    (vcc_above_low_line),
    .chip_enable_in_n      (chip_enable_in_n),
    .power_fail_in         (power_fail_in),
    .reset_n               (reset_n),
    .reset_hi              (reset_hi),
    .watchdog_fault_n      (watchdog_fault_n),
    .chip_enable_out_n     (chip_enable_out_n),
    .ram_on_backup         (ram_on_backup),
    .backup_selected       (backup_selected),
    .battery_good          (battery_good),
    .power_fail_n          (power_fail_n),
    .power_fail_oe         (power_fail_oe),
    .early_power_warning_n (early_power_warning_n),
    .seal_armed            (seal_armed)
  );

  ssw_cpu_model #(.KICK_GAP(40)) cpu (
    .ref_clk       (ref_clk),
    .kick_en       (kick_en),
    .pf_force      (pf_force),
    .power_fail_oe (power_fail_oe),
    .watchdog_kick (watchdog_kick),
    .power_fail_in (power_fail_in)
  );

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic chk_rst(input logic exp_n);
    check(reset_n, exp_n);
    check(reset_hi, !exp_n);
  endtask : chk_rst

  task automatic set_sup(input logic [4:0] v);
    {vcc_above_trip, vcc_above_switch, vcc_above_backup, vcc_above_floor, backup_above_trip} = v;
  endtask : set_sup

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Generous bound over the whole sequence
  initial begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    int n;
    tick(3);
    rst = 1'b0;
    tick(20);
    chk_rst(1'b0);
    tick(RC + 10);
    chk_rst(1'b1);
    manual_reset_n = 1'b0;
    tick(10);
    chk_rst(1'b0);
    manual_reset_n = 1'b1;
    tick(30);
    // Second cause mid-timeout must restart the count
    manual_reset_n = 1'b0;
    tick(4);
    manual_reset_n = 1'b1;
    tick(RC - 8);
    chk_rst(1'b0);
    tick(20);
    chk_rst(1'b1);
    vcc_above_trip = 1'b0;
    tick(10);
    chk_rst(1'b0);
    check(watchdog_fault_n, 1'b1);
    vcc_above_trip = 1'b1;
    tick(RC - 8);
    chk_rst(1'b0);
    tick(20);
    chk_rst(1'b1);
    backup_above_good = 1'b0;
    power_fail_sense = 1'b0;
    vcc_above_low_line = 1'b0;
    tick(8);
    check(battery_good, 1'b0);
    check(power_fail_n, 1'b0);
    check(power_fail_oe, 1'b1);
    check(early_power_warning_n, 1'b0);
    backup_above_good = 1'b1;
    power_fail_sense = 1'b1;
    vcc_above_low_line = 1'b1;
    tick(8);
    check(battery_good, 1'b1);
    check(power_fail_n, 1'b1);
    check(early_power_warning_n, 1'b1);
    set_sup(5'b00110);
    tick(8);
    check(battery_good, 1'b0);
    check(power_fail_n, 1'b0);
    check(watchdog_fault_n, 1'b0);
    set_sup(5'b11110);
    tick(RC + 15);
    kick_en = 1'b0;
    tick(120);
    check(watchdog_fault_n, 1'b1);
    tick(140);
    check(watchdog_fault_n, 1'b0);
    kick_en = 1'b1;
    tick(50);
    check(watchdog_fault_n, 1'b1);
    kick_en = 1'b0;
    for (n = 0; n < 400 && watchdog_fault_n !== 1'b0; n++)
      tick(1);
    mr_loop = 1'b1;
    for (n = 0; n < 20 && reset_hi !== 1'b1; n++)
      tick(1);
    for (n = 0; n < 3000 && watchdog_fault_n !== 1'b1; n++)
      tick(1);
    mr_loop = 1'b0;
    manual_reset_n = 1'b1;
    kick_en = 1'b1;
    check(n >= 2490 && n <= 2515, 1'b1);
    tick(RC + 20);
    chip_enable_in_n = 1'b0;
    tick(6);
    check(chip_enable_out_n, 1'b0);
    manual_reset_n = 1'b0;
    tick(1000);
    check(chip_enable_out_n, 1'b0);
    tick(1600);
    check(chip_enable_out_n, 1'b1);
    chip_enable_in_n = 1'b1;
    tick(10);
    chip_enable_in_n = 1'b0;
    tick(10);
    check(chip_enable_out_n, 1'b1);
    manual_reset_n = 1'b1;
    tick(RC + 20);
    check(chip_enable_out_n, 1'b0);
    manual_reset_n = 1'b0;
    tick(500);
    chip_enable_in_n = 1'b1;
    tick(6);
    check(chip_enable_out_n, 1'b1);
    manual_reset_n = 1'b1;
    tick(RC + 20);
    for (int i = 0; i < 10; i++) begin
      set_sup(sup_tab[i][5:1]);
      tick(10);
      check(ram_on_backup, sup_tab[i][0]);
      check(backup_selected, sup_tab[i][0]);
    end
    tick(RC + 20);
    set_sup(5'b01110);
    tick(10);
    pf_force = 1'b1;
    tick(10);
    set_sup(5'b11110);
    tick(2);
    // Manual reset ignored early in timeout while pin held low
    manual_reset_n = 1'b0;
    tick(10);
    manual_reset_n = 1'b1;
    tick(RC - 2);
    chk_rst(1'b1);
    tick(10);
    // Supply drop that would normally pick the backup
    set_sup(5'b00010);
    tick(10);
    check(seal_armed, 1'b1);
    check(ram_on_backup, 1'b0);
    pf_force = 1'b0;
    set_sup(5'b11110);
    tick(10);
    check(seal_armed, 1'b0);
    end_of_test();
  end
endmodule : test_ssw_top
`default_nettype wire
